//--- src/flash_read_pkg.sv
// Constants and types shared by the serial flash read front end
package flash_read_pkg;

   // Opcodes of the two continuous main-array reads
   localparam logic [7:0]  OP_LEGACY_READ    = 8'he8;
   localparam logic [7:0]  OP_FAST_READ      = 8'h0b;

   // Frame lengths in serial clock rising edges
   localparam logic [5:0]  OPCODE_BITS       = 6'h08;
   localparam logic [5:0]  ADDR_BITS         = 6'h18;
   localparam logic [5:0]  LEGACY_DUMMY_BITS = 6'h20;
   localparam logic [5:0]  FAST_DUMMY_BITS   = 6'h08;

   // Address field layout
   localparam int          PAGE_W            = 10;
   localparam int          OFFS_W            = 9;
   localparam int          INDEX_W           = 19;
   localparam int          EXT_PAGE_LSB      = 9;
   localparam int          STD_PAGE_LSB      = 8;

   // Array geometry
   localparam logic [8:0]  LAST_BYTE_STD     = 9'h0ff;
   localparam logic [8:0]  LAST_BYTE_EXT     = 9'h107;
   localparam logic [9:0]  LAST_PAGE         = 10'h3ff;
   localparam logic [18:0] ARRAY_BYTES       = 19'h42000;

   // Reset values
   localparam logic [7:0]  BYTE_RESET        = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } state_t;

endpackage

//--- src/array_memory.sv
// Main array byte store with registered read data
`timescale 1ns/1ps
module array_memory (
   input  wire logic                                clk,
   input  wire logic                                wr_en,
   input  wire logic [flash_read_pkg::INDEX_W-1:0]  wr_addr,
   input  wire logic [7:0]                          wr_data,
   input  wire logic                                rd_en,
   input  wire logic [flash_read_pkg::INDEX_W-1:0]  rd_addr,
   output logic      [7:0]                          rd_data
);

   logic [7:0] mem [0:flash_read_pkg::ARRAY_BYTES-1];

   wire wr_in_range = wr_addr < flash_read_pkg::ARRAY_BYTES;
   wire rd_in_range = rd_addr < flash_read_pkg::ARRAY_BYTES;

   always_ff @(posedge clk) begin
      if (wr_en && wr_in_range) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Out of range reads return zero
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= rd_in_range ? mem[rd_addr] : flash_read_pkg::BYTE_RESET;
      end
   end

endmodule

//--- src/flash_read_front.sv
// Serial flash command front end for continuous main-array reads
//
// Summary of operation
// - Chip select fall starts eight-bit opcode, address
// - All fields shifted most significant bit first
// - Exactly three address bytes, leading bits don't-care
// - Large page: nine-bit buffer byte address
// - Large page: ten-bit page, nine-bit offset
// - Default page: eight-bit buffer byte address
// - Default page: upper ten page, lower eight byte
// - Legacy read: opcode, address, four dummy bytes
// - Fast read: opcode, address, one dummy byte
// - Address counter advances itself while streaming
// - Page end continues at next page, no gap
// - Array end wraps to first page, no gap
// - Chip select rise ends read, output released
// - Reads fetch from array, buffer untouched
// - Both serial clock modes 0 and 3 accepted
// - Sample input on rise, drive output on fall
// - Reset low aborts and holds idle
`timescale 1ns/1ps
module flash_read_front (
   input  wire logic                                clk,
   input  wire logic                                rstn,
   input  wire logic                                cs_n,
   input  wire logic                                sck,
   input  wire logic                                si,
   input  wire logic                                page_264,
   input  wire logic                                load_en,
   input  wire logic [flash_read_pkg::INDEX_W-1:0]  load_addr,
   input  wire logic [7:0]                          load_data,
   output logic                                     so,
   output logic                                     so_oe,
   output logic      [flash_read_pkg::PAGE_W-1:0]   page_number_bits,
   output logic      [flash_read_pkg::OFFS_W-1:0]   page_byte_offset_bits,
   output logic      [flash_read_pkg::OFFS_W-1:0]   buffer_offset
);

   // Page number from the 24-bit address field
   function automatic logic [flash_read_pkg::PAGE_W-1:0] decode_page(
      input logic [23:0] a,
      input logic        ext
   );
      if (ext) begin
         decode_page = a[flash_read_pkg::EXT_PAGE_LSB +: flash_read_pkg::PAGE_W];
      end else begin
         decode_page = a[flash_read_pkg::STD_PAGE_LSB +: flash_read_pkg::PAGE_W];
      end
   endfunction

   // Byte offset within the page
   function automatic logic [flash_read_pkg::OFFS_W-1:0] decode_offset(
      input logic [23:0] a,
      input logic        ext
   );
      if (ext) begin
         decode_offset = a[flash_read_pkg::OFFS_W-1:0];
      end else begin
         decode_offset = {1'b0, a[7:0]};
      end
   endfunction

   // Buffer byte address
   function automatic logic [flash_read_pkg::OFFS_W-1:0] decode_buffer(
      input logic [23:0] a,
      input logic        ext
   );
      if (ext) begin
         decode_buffer = a[flash_read_pkg::OFFS_W-1:0];
      end else begin
         decode_buffer = {1'b0, a[7:0]};
      end
   endfunction

   logic                                   sck_q;
   logic                                   cs_q;
   flash_read_pkg::state_t                 state;
   logic [5:0]                             bit_cnt;
   logic [7:0]                             op;
   logic [23:0]                            addr_sr;
   logic                                   legacy;
   logic [flash_read_pkg::PAGE_W-1:0]      ptr_page;
   logic [flash_read_pkg::OFFS_W-1:0]      ptr_byte;
   logic                                   fetch;
   logic [7:0]                             out_sr;
   logic [2:0]                             out_bit;
   logic [7:0]                             rd_data;

   // Edge detection of the host pins
   wire sck_rise = sck & ~sck_q;
   wire sck_fall = ~sck & sck_q;
   wire cs_fall  = ~cs_n & cs_q;

   // Shift paths, MSB first
   wire [7:0]  next_op   = {op[6:0], si};
   wire [23:0] next_addr = {addr_sr[22:0], si};

   wire op_known  = (next_op == flash_read_pkg::OP_LEGACY_READ) ||
                    (next_op == flash_read_pkg::OP_FAST_READ);
   wire op_done   = (state == flash_read_pkg::ST_OPCODE) && sck_rise &&
                    (bit_cnt == flash_read_pkg::OPCODE_BITS - 6'h01);
   wire addr_done = (state == flash_read_pkg::ST_ADDR) && sck_rise && !cs_n &&
                    (bit_cnt == flash_read_pkg::ADDR_BITS - 6'h01);

   wire [5:0] dummy_last = legacy ? flash_read_pkg::LEGACY_DUMMY_BITS - 6'h01
                                  : flash_read_pkg::FAST_DUMMY_BITS - 6'h01;

   wire dummy_done = (state == flash_read_pkg::ST_DUMMY) && sck_rise &&
                     (bit_cnt == dummy_last);

   // Byte load moment in the data phase
   wire data_fall = (state == flash_read_pkg::ST_DATA) && sck_fall && !cs_n;
   wire load      = data_fall && (out_bit == 3'h0);

   // Sequential address advance
   wire [8:0] last_byte   = page_264 ? flash_read_pkg::LAST_BYTE_EXT
                                     : flash_read_pkg::LAST_BYTE_STD;
   wire       at_page_end = ptr_byte >= last_byte;
   wire       at_last_pg  = ptr_page == flash_read_pkg::LAST_PAGE;
   wire [flash_read_pkg::OFFS_W-1:0] next_byte =
      at_page_end ? '0 : ptr_byte + 9'h001;
   wire [flash_read_pkg::PAGE_W-1:0] next_page =
      !at_page_end ? ptr_page : (at_last_pg ? '0 : ptr_page + 10'h001);

   // Linear array index of the pointer
   wire [18:0] page_x256 = {1'b0, ptr_page, 8'h00};
   wire [18:0] page_x8   = {6'h00, ptr_page, 3'h0};
   wire [18:0] byte_ext  = {10'h000, ptr_byte};
   wire [flash_read_pkg::INDEX_W-1:0] fetch_index =
      page_264 ? page_x256 + page_x8 + byte_ext : {1'b0, ptr_page, ptr_byte[7:0]};

   // Pin history for edge detection
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sck_q <= 1'b0;
         cs_q  <= 1'b0;
      end else begin
         sck_q <= sck;
         cs_q  <= cs_n;
      end
   end

   // Command framing state machine
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state   <= flash_read_pkg::ST_IDLE;
         bit_cnt <= 6'h00;
         op      <= 8'h00;
         addr_sr <= 24'h000000;
         legacy  <= 1'b0;
      end else if (cs_n) begin
         state   <= flash_read_pkg::ST_IDLE;
         bit_cnt <= 6'h00;
      end else begin
         case (state)
            flash_read_pkg::ST_IDLE: begin
               if (cs_fall) begin
                  state   <= flash_read_pkg::ST_OPCODE;
                  bit_cnt <= 6'h00;
               end
            end
            flash_read_pkg::ST_OPCODE: begin
               if (sck_rise) begin
                  op      <= next_op;
                  bit_cnt <= bit_cnt + 6'h01;
               end
               if (op_done) begin
                  bit_cnt <= 6'h00;
                  legacy  <= next_op == flash_read_pkg::OP_LEGACY_READ;
                  state   <= op_known ? flash_read_pkg::ST_ADDR : flash_read_pkg::ST_IGNORE;
               end
            end
            flash_read_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  addr_sr <= next_addr;
                  bit_cnt <= bit_cnt + 6'h01;
               end
               if (addr_done) begin
                  bit_cnt <= 6'h00;
                  state   <= flash_read_pkg::ST_DUMMY;
               end
            end
            flash_read_pkg::ST_DUMMY: begin
               if (sck_rise) begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
               if (dummy_done) begin
                  bit_cnt <= 6'h00;
                  state   <= flash_read_pkg::ST_DATA;
               end
            end
            flash_read_pkg::ST_DATA: begin
               state <= flash_read_pkg::ST_DATA;
            end
            flash_read_pkg::ST_IGNORE: begin
               state <= flash_read_pkg::ST_IGNORE;
            end
            default: begin
               state <= flash_read_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Decoded start address and read pointer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         page_number_bits      <= '0;
         page_byte_offset_bits <= '0;
         buffer_offset         <= '0;
         ptr_page              <= '0;
         ptr_byte              <= '0;
         fetch                 <= 1'b0;
      end else if (addr_done) begin
         page_number_bits      <= decode_page(next_addr, page_264);
         page_byte_offset_bits <= decode_offset(next_addr, page_264);
         buffer_offset         <= decode_buffer(next_addr, page_264);
         ptr_page              <= decode_page(next_addr, page_264);
         ptr_byte              <= decode_offset(next_addr, page_264);
         fetch                 <= 1'b1;
      end else if (load) begin
         ptr_page <= next_page;
         ptr_byte <= next_byte;
         fetch    <= 1'b1;
      end else begin
         fetch <= 1'b0;
      end
   end

   // Serial output, driven on falling edges
   always_ff @(posedge clk) begin
      if (!rstn) begin
         so      <= 1'b0;
         so_oe   <= 1'b0;
         out_sr  <= flash_read_pkg::BYTE_RESET;
         out_bit <= 3'h0;
      end else if (cs_n || state != flash_read_pkg::ST_DATA) begin
         so_oe   <= 1'b0;
         out_bit <= 3'h0;
      end else if (data_fall) begin
         so_oe   <= 1'b1;
         so      <= load ? rd_data[7] : out_sr[7];
         out_sr  <= load ? {rd_data[6:0], 1'b0} : {out_sr[6:0], 1'b0};
         out_bit <= out_bit + 3'h1;
      end
   end

   // Array store, read only on this path
   array_memory array_memory_i (
      .clk     (clk),
      .wr_en   (load_en),
      .wr_addr (load_addr),
      .wr_data (load_data),
      .rd_en   (fetch),
      .rd_addr (fetch_index),
      .rd_data (rd_data)
   );

   // Checks
   a_cs_release: assert property (
      @(posedge clk) disable iff (!rstn)
      cs_n |=> !so_oe)
      else $error("serial output driven after chip select rose");

   a_reset_idle: assert property (
      @(posedge clk)
      !rstn |=> (state == flash_read_pkg::ST_IDLE) && !so_oe)
      else $error("reset did not return to idle");

   a_so_on_fall: assert property (
      @(posedge clk) disable iff (!rstn)
      (so_oe && $changed(so)) |-> $past(sck_fall))
      else $error("serial output changed without a falling clock");

   a_opcode_len: assert property (
      @(posedge clk) disable iff (!rstn)
      (state == flash_read_pkg::ST_OPCODE && !cs_n && sck_rise && bit_cnt < 6'h07)
      |=> state == flash_read_pkg::ST_OPCODE)
      else $error("opcode phase ended early");

   a_ext_decode: assert property (
      @(posedge clk) disable iff (!rstn)
      (addr_done && page_264) |=>
      (page_number_bits == $past(next_addr[18:9])) &&
      (page_byte_offset_bits == $past(next_addr[8:0])))
      else $error("large page address decode wrong");

   a_std_decode: assert property (
      @(posedge clk) disable iff (!rstn)
      (addr_done && !page_264) |=>
      (page_number_bits == $past(next_addr[17:8])) &&
      (page_byte_offset_bits == {1'b0, $past(next_addr[7:0])}))
      else $error("default page address decode wrong");

   a_buffer_decode: assert property (
      @(posedge clk) disable iff (!rstn)
      addr_done |=> buffer_offset ==
      ($past(page_264) ? $past(next_addr[8:0]) : {1'b0, $past(next_addr[7:0])}))
      else $error("buffer address decode wrong");

   a_legacy_dummy: assert property (
      @(posedge clk) disable iff (!rstn)
      (state == flash_read_pkg::ST_DUMMY && legacy && !cs_n && sck_rise && bit_cnt == 6'h1f)
      |=> state == flash_read_pkg::ST_DATA)
      else $error("legacy read dummy length wrong");

   a_fast_dummy: assert property (
      @(posedge clk) disable iff (!rstn)
      (state == flash_read_pkg::ST_DUMMY && !legacy && !cs_n && sck_rise && bit_cnt == 6'h07)
      |=> state == flash_read_pkg::ST_DATA)
      else $error("fast read dummy length wrong");

   a_page_cross: assert property (
      @(posedge clk) disable iff (!rstn)
      (load && at_page_end && !at_last_pg) |=>
      (ptr_byte == '0) && (ptr_page == $past(ptr_page) + 10'h001) && fetch)
      else $error("page crossing did not move to next page");

   a_array_wrap: assert property (
      @(posedge clk) disable iff (!rstn)
      (load && at_page_end && at_last_pg) |=> (ptr_byte == '0) && (ptr_page == '0))
      else $error("array end did not wrap to first page");

   a_auto_advance: assert property (
      @(posedge clk) disable iff (!rstn)
      (load && !at_page_end) |=>
      (ptr_byte == $past(ptr_byte) + 9'h001) && (ptr_page == $past(ptr_page)) ##1 !fetch)
      else $error("address counter did not advance");

endmodule

//--- sim/spi_host_model.sv
// Host controller model that frames continuous reads on the serial link
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic       clk,
   output logic            cs_n,
   output logic            sck,
   output logic            si,
   input  wire logic       so,
   input  wire logic       so_oe,
   output logic            got_valid,
   output logic [7:0]      got_byte
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      got_valid = 1'b0;
      got_byte = 8'h00;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Header bits, whole data bytes, then release; stop cuts the header short
   task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int dum,
                        input int nbytes, input bit m3, input int half, input int stop);
      logic [63:0] hdr;
      logic [7:0]  b;
      int          nb;
      hdr = {op, ad, 32'h5ac3_96e1};
      nb = (stop > 0) ? stop : 32 + 8 * dum;
      sck = m3;
      wait_clk(1);
      cs_n = 1'b0;
      wait_clk(half);
      for (int i = 0; i < nb; i++) begin
         sck = 1'b0;
         si = hdr[63-i];
         wait_clk(half);
         sck = 1'b1;
         wait_clk(half);
      end
      for (int k = 0; k < nbytes; k++) begin
         for (int j = 7; j >= 0; j--) begin
            sck = 1'b0;
            si = ~si;
            wait_clk(half);
            b[j] = so_oe ? so : ~so;
            sck = 1'b1;
            wait_clk(half);
         end
         got_byte = b;
         got_valid = 1'b1;
         wait_clk(1);
         got_valid = 1'b0;
      end
      sck = m3;
      wait_clk(half);
      cs_n = 1'b1;
      si = ~si;
   endtask
endmodule

//--- sim/test_flash_read_front.sv
// Self-checking bench for the continuous read front end
`timescale 1ns/1ps
module test_flash_read_front;
   logic        clk;
   logic        rstn;
   logic        page_264;
   logic        load_en;
   logic [18:0] load_addr;
   logic [7:0]  load_data;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        got_valid;
   logic [7:0]  got_byte;
   logic [9:0]  page_number_bits;
   logic [8:0]  page_byte_offset_bits;
   logic [8:0]  buffer_offset;
   logic [7:0]  mem [int];
   logic [7:0]  exp_q [$];
   int          bad_count = 0;
   int          checks_done = 0;
   int          oe_seen = 0;
   bit          quiet = 1'b0;
   logic [8:0]  ps;
   logic [9:0]  pg;
   logic [8:0]  off;

   flash_read_front flash_read_front_i (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck),
      .si(si), .page_264(page_264), .load_en(load_en), .load_addr(load_addr),
      .load_data(load_data), .so(so), .so_oe(so_oe), .page_number_bits(page_number_bits),
      .page_byte_offset_bits(page_byte_offset_bits), .buffer_offset(buffer_offset));

   spi_host_model spi_host_model_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
      .so_oe(so_oe), .got_valid(got_valid), .got_byte(got_byte));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic print_verdict();
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic load(input int idx, input logic [7:0] d);
      mem[idx] = d;
      load_addr = 19'(idx);
      load_data = d;
      load_en = 1'b1;
      @(negedge clk);
      load_en = 1'b0;
      @(negedge clk);
   endtask

   // Notes the expected stream, then lets the host run the frame
   task automatic read(input logic [7:0] op, input logic [9:0] p0, input logic [8:0] o0,
                       input int n, input bit m3, input int half);
      logic [23:0] a;
      int          p;
      int          o;
      int          idx;
      int          sz;
      sz = page_264 ? 264 : 256;
      a = 24'($urandom);
      if (page_264)
         a[18:0] = {p0, o0};
      else
         a[17:0] = {p0, o0[7:0]};
      p = p0;
      o = o0;
      for (int k = 0; k < n; k++) begin
         idx = p * sz + o;
         if (!mem.exists(idx))
            load(idx, 8'($urandom));
         exp_q.push_back(mem[idx]);
         o++;
         if (o >= sz) begin
            o = 0;
            p = (p + 1) % 1024;
         end
      end
      spi_host_model_i.frame(op, a, (op == flash_read_pkg::OP_LEGACY_READ) ? 4 : 1,
                             n, m3, half, 0);
      repeat (3) @(negedge clk);
      check(32'(page_number_bits), 32'(p0));
      check(32'(page_byte_offset_bits), 32'(o0));
      check(32'(buffer_offset), 32'(o0));
      check(32'(so_oe), 32'h0);
   endtask

   always @(posedge clk) begin
      if (quiet && so_oe !== 1'b0)
         oe_seen++;
      else if (!quiet && got_valid === 1'b1)
         check(32'(got_byte), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'h100);
   end

   initial begin
      rstn = 1'b0;
      page_264 = 1'b0;
      load_en = 1'b0;
      load_addr = 19'h00000;
      load_data = 8'h00;
      void'($urandom(32'h941a));
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      for (int c = 0; c < 7; c++) begin
         page_264 = c[1];
         ps = c[1] ? 9'h108 : 9'h100;
         pg = (c < 4) ? 10'h3ff : 10'($urandom % 1023);
         off = (c < 4) ? ps - 9'h002 : (c == 4) ? ps - 9'h001 : 9'($urandom % ps);
         @(negedge clk);
         read(c[0] ? flash_read_pkg::OP_LEGACY_READ : flash_read_pkg::OP_FAST_READ,
              pg, off, 4, c[0] ^ c[1], c[0] ? 5 : 3);
         if (c == 5) begin
            quiet = 1'b1;
            spi_host_model_i.frame(8'h03, 24'h000100, 1, 2, 1'b0, 3, 0);
            spi_host_model_i.frame(flash_read_pkg::OP_FAST_READ, 24'h0, 1, 0, 1'b0, 3, 20);
            fork
               spi_host_model_i.frame(flash_read_pkg::OP_FAST_READ, 24'h012345, 1, 2,
                                      1'b0, 3, 0);
               begin
                  repeat (10) @(negedge clk);
                  rstn = 1'b0;
                  repeat (3) @(negedge clk);
                  rstn = 1'b1;
               end
            join
            quiet = 1'b0;
            check(32'(oe_seen), 32'h0);
            check(32'(page_number_bits), 32'h0);
            check(32'(page_byte_offset_bits), 32'h0);
         end
      end
      check(32'(exp_q.size()), 32'h0);
      print_verdict();
   end
endmodule
